// file: src/srr_pkg.sv
// Purpose: Shared constants, register map and types of the speed reference regulator.
// Assumes: 20 MHz control clock; speeds and currents in units of 0.1 percent.
// Notes: Parameter words sit in a table reached at PRM_BASE plus four times the index.
package srr_pkg;
  // Clock and timing
  localparam int CLK_HZ = 20_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TUNE_SETTLE_MS = 200; // Settling time after each field step
  localparam int TUNE_SETTLE_CYC = TUNE_SETTLE_MS * CYC_PER_MS;
  // Fixed-point scales
  localparam int PCT_FULL = 1000; // 100.0 percent
  localparam int FRAC_BITS = 16; // Fraction bits of ramp and integrator
  localparam int KP_DIV = 100; // Gains are in hundredths
  localparam int GAIN_DIV = 1000; // Torque gain is in tenths of percent
  localparam int UV100_PER_MV = 10; // Offset steps of 100 uV per millivolt
  localparam int INTERP_ONE = 256; // Interpolation factor of one
  localparam logic [15:0] STEP_ANGLE = 16'h5555; // 120 electrical degrees
  localparam logic [1:0] TUNE_STEPS = 2'h3; // Three steps make one turn
  localparam logic [15:0] ACCESS_KEY_CODE = 16'h005f;
  // Tune command codes
  localparam logic [1:0] CMD_START = 2'h1;
  localparam logic [1:0] CMD_CLEAR = 2'h2;
  // Control register bits
  localparam int CB_SEL_A = 0;
  localparam int CB_SEL_B = 1;
  localparam int CB_INVERT = 2;
  localparam int CB_RAMP = 3;
  localparam int CB_CW_OK = 4;
  localparam int CB_CCW_OK = 5;
  localparam int CB_SPT = 6;
  localparam int CB_INT_DIS = 7;
  localparam logic [7:0] CTRL_RESET = 8'h30; // Both limit bits set
  // Byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] PRM_BASE = 8'h04;
  localparam logic [7:0] A_TUNE = 8'h5c;
  localparam logic [7:0] A_STATUS = 8'h60;
  localparam logic [7:0] A_PHASE = 8'h64;
  localparam logic [7:0] A_SREF = 8'h68;
  localparam logic [7:0] A_CUR = 8'h6c;
  // Parameter table indices
  localparam int NPRM = 22;
  localparam int P_PRESET1 = 0;
  localparam int P_PRESET2 = 1;
  localparam int P_PRESET3 = 2;
  localparam int P_REF_OFS = 3;
  localparam int P_FS_MV = 4;
  localparam int P_CW_LIM = 5;
  localparam int P_CCW_LIM = 6;
  localparam int P_CW_ACC = 7;
  localparam int P_CW_DEC = 8;
  localparam int P_CCW_ACC = 9;
  localparam int P_CCW_DEC = 10;
  localparam int P_TQ_OFS = 11;
  localparam int P_TQ_GAIN = 12;
  localparam int P_BREAK = 13;
  localparam int P_HI_KP = 14;
  localparam int P_HI_TA = 15;
  localparam int P_LO_KP = 16;
  localparam int P_LO_TA = 17;
  localparam int P_PRELOAD = 18;
  localparam int P_MOT_POLES = 19;
  localparam int P_RES_POLES = 20;
  localparam int P_KEY = 21;

  // Auto-tune sequence states
  typedef enum logic [2:0] {TS_IDLE, TS_POLE, TS_DIR, TS_STEP, TS_CALC, TS_ALARM} srr_tune_t;

  // Reset value of each parameter word
  function automatic logic [15:0] prm_reset(input int idx);
    case (idx)
      P_FS_MV: prm_reset = 16'h2710; // 10000 mV
      P_CW_LIM, P_CCW_LIM: prm_reset = 16'h03e8; // 100.0 percent
      P_TQ_GAIN: prm_reset = 16'h03e8; // Gain of one
      P_HI_KP, P_LO_KP: prm_reset = 16'h0064; // Gain of one
      P_HI_TA, P_LO_TA: prm_reset = 16'h0014; // 20 ms
      P_MOT_POLES: prm_reset = 16'h0006;
      P_RES_POLES: prm_reset = 16'h0002;
      default: prm_reset = 16'h0000;
    endcase
  endfunction : prm_reset
endpackage : srr_pkg

// file: src/srr_speed_regulator.sv
// Purpose: Speed reference chain, PI speed regulator and resolver phase auto-tune.
// Assumes: APB slave with zero wait states; analog values arrive already digitised.
// Notes: Every clock edge is one control cycle; select, limit switch and torque mode pins pass a two-stage synchroniser.
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ps

// Overview of operation
// - Tune starts stopped, keyed, command one
// - Tune checks poles, direction, steps, stores phase
// - Pole ratio fault raises pole alarm
// - Direction fault raises phase order alarm
// - Alarm halts until clear and new command
// - Select inputs pick analog or preset
// - Software bits same code, override inputs when not both zero
// - Invert bit negates external reference
// - Ten volts differential means maximum speed
// - Signed offset subtracted from analog reference
// - Full-scale millivolts sets maximum speed point
// - Presets are signed percent of maximum
// - Separate clockwise and counterclockwise limits clamp
// - Optional linear ramp, four times
// - Open switch or bit zeroes reference
// - Stopped at switch blocks same direction
// - Torque mode uses offset, gain torque input
// - Speed plus torque adds feed-forward
// - Gains interpolated by speed over breakpoint
// - Zero breakpoint uses low-speed gains only
// - Integral disable bit removes integral action
// - Integrator preloaded at drive start
// - Percentages scale to maximum speed
module srr_speed_regulator import srr_pkg::*; #(
  parameter int SETTLE_CYC = TUNE_SETTLE_CYC // Shorten in simulation
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_select_a_input,
  input wire logic ref_select_b_input,
  input wire logic cw_limit_switch,
  input wire logic ccw_limit_switch,
  input wire logic torque_mode_select,
  input wire logic drive_running,
  input wire logic signed [17:0] analog_ref_in,
  input wire logic signed [15:0] torque_ref_input,
  input wire logic signed [15:0] speed_fb,
  input wire logic [15:0] resolver_angle,
  output logic signed [15:0] speed_ref_out,
  output logic signed [15:0] current_cmd,
  output logic tune_active,
  output logic [15:0] tune_field_angle,
  output logic pole_mismatch_alarm,
  output logic phase_order_alarm,
  output logic [15:0] resolver_phase_offset
);

  // Whole state of the block
  typedef struct packed {
    logic [NPRM-1:0][15:0] prm; // Parameter words
    logic [7:0] ctrl; // Control bits
    logic [4:0] sync1; // First synchroniser stage
    logic [4:0] sync2; // Second synchroniser stage
    logic cw_lock; // Clockwise motion blocked
    logic ccw_lock; // Counterclockwise motion blocked
    logic signed [31:0] ramp; // Ramp output with fraction
    logic signed [47:0] integ; // Integrator with fraction
    logic signed [15:0] sref; // Final speed reference
    logic signed [15:0] cur; // Current command
    srr_tune_t st; // Auto-tune state
    logic [23:0] tmr; // Settling timer
    logic [1:0] steps; // Field steps done
    logic [15:0] field; // Field angle during tune
    logic [15:0] ang0; // Resolver angle at direction step start
    logic [15:0] phase; // Stored phase offset
    logic pole_al; // Pole mismatch alarm
    logic order_al; // Phase order alarm
    logic [31:0] rdata; // Registered read data
  } srr_state_t;

  srr_state_t s_r, s_nxt; // Registered state and its next value

  // Decodes an address into a parameter index, or -1 when outside the table
  function automatic int prm_index(input logic [7:0] a);
    if (a >= PRM_BASE && a < A_TUNE && a[1:0] == 2'h0) begin
      prm_index = int'((a - PRM_BASE) >> 2);
    end else begin
      prm_index = -1;
    end
  endfunction : prm_index

  // Clamps a value to a signed symmetric or asymmetric range
  function automatic int clamp(input int v, input int lo, input int hi);
    clamp = (v > hi) ? hi : ((v < lo) ? lo : v);
  endfunction : clamp

  // Ramp step per cycle for a time in ms; zero time jumps at once
  function automatic int ramp_step(input logic [15:0] t_ms);
    if (t_ms == 16'h0000) begin
      ramp_step = (PCT_FULL * 2) << FRAC_BITS;
    end else begin
      ramp_step = ((PCT_FULL << FRAC_BITS) / (int'(t_ms) * CYC_PER_MS));
      if (ramp_step < 1) ramp_step = 1;
    end
  endfunction : ramp_step

  logic wr_acc; // Write in access phase
  logic rd_setup; // Read in setup phase
  logic map_ok; // Address is mapped
  logic start_ok; // Tune start conditions met
  logic clr_wr; // Alarm clear written
  logic ratio_ok; // Pole ratio valid
  logic signed [15:0] dir_delta; // Resolver travel during direction step
  logic [1:0] sel; // Effective reference select, a then b
  logic signed [15:0] tgt; // Gated reference target

  assign pready = 1'b1; // Zero wait states
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign map_ok = (paddr == A_CTRL) || (prm_index(paddr) >= 0) || (paddr == A_TUNE)
    || (paddr == A_STATUS) || (paddr == A_PHASE) || (paddr == A_SREF) || (paddr == A_CUR);
  assign pslverr = psel && penable && !map_ok;
  assign start_ok = wr_acc && paddr == A_TUNE && pwdata[1:0] == CMD_START
    && !drive_running && s_r.prm[P_KEY] == ACCESS_KEY_CODE && s_r.st == TS_IDLE;
  assign clr_wr = wr_acc && paddr == A_TUNE && pwdata[1:0] == CMD_CLEAR;
  assign ratio_ok = s_r.prm[P_RES_POLES] != 16'h0000 && s_r.prm[P_MOT_POLES] != 16'h0000
    && (s_r.prm[P_MOT_POLES] % s_r.prm[P_RES_POLES]) == 16'h0000;
  assign dir_delta = $signed(resolver_angle - s_r.ang0);

  // Whole next-state computation
  always_comb begin
    int idx;
    int aref;
    int ref_sel;
    int cwl;
    int ccwl;
    int t;
    int r;
    int stp;
    int fs;
    int err;
    int kp;
    int ta;
    int frac;
    int tq;
    longint pi;
    longint inc;
    idx = prm_index(paddr);
    aref = 0;
    ref_sel = 0;
    cwl = 0;
    ccwl = 0;
    t = 0;
    r = 0;
    stp = 0;
    fs = 0;
    err = 0;
    kp = 0;
    ta = 0;
    frac = 0;
    tq = 0;
    pi = 0;
    inc = 0;
    s_nxt = s_r;
    // Pin synchronisers
    s_nxt.sync1 = {torque_mode_select, ccw_limit_switch, cw_limit_switch,
                   ref_select_b_input, ref_select_a_input};
    s_nxt.sync2 = s_r.sync1;

    // Register writes take effect in the access phase
    if (wr_acc) begin
      if (paddr == A_CTRL) begin
        s_nxt.ctrl = pwdata[7:0];
      end else if (idx >= 0) begin
        s_nxt.prm[idx] = pwdata[15:0];
      end
    end

    // Reference select: bits win when not both zero
    if (s_r.ctrl[CB_SEL_A] || s_r.ctrl[CB_SEL_B]) begin
      sel = {s_r.ctrl[CB_SEL_A], s_r.ctrl[CB_SEL_B]};
    end else begin
      sel = s_r.sync2[1:0] == 2'b01 ? 2'b10 : (s_r.sync2[1:0] == 2'b10 ? 2'b01 : s_r.sync2[1:0]);
    end
    // Analog: offset in 100 uV removed, full scale in mV maps to 100.0 percent
    fs = (s_r.prm[P_FS_MV] == 16'h0000) ? 1 : int'(s_r.prm[P_FS_MV]);
    aref = int'(analog_ref_in) - int'($signed(s_r.prm[P_REF_OFS]));
    aref = (aref * PCT_FULL) / (fs * UV100_PER_MV);
    if (s_r.ctrl[CB_INVERT]) aref = -aref;
    case (sel)
      2'b10: ref_sel = aref;
      2'b01: ref_sel = int'($signed(s_r.prm[P_PRESET1]));
      2'b11: ref_sel = int'($signed(s_r.prm[P_PRESET2]));
      default: ref_sel = int'($signed(s_r.prm[P_PRESET3]));
    endcase
    // Per-direction limits
    cwl = int'(s_r.prm[P_CW_LIM]);
    ccwl = int'(s_r.prm[P_CCW_LIM]);
    ref_sel = clamp(ref_sel, -ccwl, cwl);
    // Limit switch blocking, released only by a reversed reference
    if ((!s_r.sync2[2] || !s_r.ctrl[CB_CW_OK]) && ref_sel > 0) s_nxt.cw_lock = 1'b1;
    else if (ref_sel < 0) s_nxt.cw_lock = 1'b0;
    if ((!s_r.sync2[3] || !s_r.ctrl[CB_CCW_OK]) && ref_sel < 0) s_nxt.ccw_lock = 1'b1;
    else if (ref_sel > 0) s_nxt.ccw_lock = 1'b0;
    if ((s_nxt.cw_lock && ref_sel > 0) || (s_nxt.ccw_lock && ref_sel < 0)) ref_sel = 0;
    tgt = 16'(ref_sel);

    // Ramp; a blocked direction stops at once without ramp
    t = ref_sel <<< FRAC_BITS;
    r = s_r.ramp;
    if (!s_r.ctrl[CB_RAMP] || (ref_sel == 0 && (s_nxt.cw_lock || s_nxt.ccw_lock))) begin
      r = t;
    end else begin
      if (r >= 0 && t > r) stp = ramp_step(s_r.prm[P_CW_ACC]);
      else if (r > 0) stp = ramp_step(s_r.prm[P_CW_DEC]);
      else if (t < r) stp = ramp_step(s_r.prm[P_CCW_ACC]);
      else stp = ramp_step(s_r.prm[P_CCW_DEC]);
      if (t > r) r = (t - r > stp) ? r + stp : t;
      else r = (r - t > stp) ? r - stp : t;
    end
    r = clamp(r, -(ccwl <<< FRAC_BITS), cwl <<< FRAC_BITS);
    s_nxt.ramp = r;
    s_nxt.sref = 16'(r >>> FRAC_BITS);

    // Gain interpolation by speed plus reference over breakpoint
    if (s_r.prm[P_BREAK] == 16'h0000) begin
      kp = int'(s_r.prm[P_LO_KP]);
      ta = int'(s_r.prm[P_LO_TA]);
    end else begin
      frac = ((int'(speed_fb < 0 ? -speed_fb : speed_fb) + int'(s_r.sref < 0 ? -s_r.sref : s_r.sref))
              * INTERP_ONE) / int'(s_r.prm[P_BREAK]);
      if (frac > INTERP_ONE) frac = INTERP_ONE;
      kp = int'(s_r.prm[P_LO_KP]) + ((int'(s_r.prm[P_HI_KP]) - int'(s_r.prm[P_LO_KP])) * frac) / INTERP_ONE;
      ta = int'(s_r.prm[P_LO_TA]) + ((int'(s_r.prm[P_HI_TA]) - int'(s_r.prm[P_LO_TA])) * frac) / INTERP_ONE;
    end
    if (ta < 1) ta = 1;
    err = int'(s_r.sref) - int'(speed_fb);
    // Integrator: preload while stopped, frozen at zero when disabled
    if (!drive_running) begin
      s_nxt.integ = 48'(longint'($signed(s_r.prm[P_PRELOAD])) <<< FRAC_BITS);
    end else if (s_r.ctrl[CB_INT_DIS]) begin
      s_nxt.integ = '0;
    end else begin
      inc = (longint'(err) * kp <<< FRAC_BITS) / (longint'(KP_DIV) * ta * CYC_PER_MS);
      s_nxt.integ = 48'(clamp_l(s_r.integ + inc));
    end
    pi = longint'(err) * kp / KP_DIV + (s_r.integ >>> FRAC_BITS);
    tq = ((int'(torque_ref_input) - int'($signed(s_r.prm[P_TQ_OFS])))
          * int'($signed(s_r.prm[P_TQ_GAIN]))) / GAIN_DIV;
    if (s_r.sync2[4]) pi = tq;
    else if (s_r.ctrl[CB_SPT]) pi = pi + tq;
    if (pi > PCT_FULL) pi = PCT_FULL;
    if (pi < -PCT_FULL) pi = -PCT_FULL;
    s_nxt.cur = drive_running ? 16'(pi) : 16'h0000;

    // Auto-tune sequence
    case (s_r.st)
      TS_IDLE: begin
        if (start_ok) begin
          s_nxt.st = TS_POLE;
          s_nxt.field = 16'h0000;
          s_nxt.steps = 2'h0;
        end
      end
      TS_POLE: begin
        if (!ratio_ok) begin
          s_nxt.st = TS_ALARM;
          s_nxt.pole_al = 1'b1;
        end else begin
          s_nxt.st = TS_DIR;
          s_nxt.ang0 = resolver_angle;
          s_nxt.field = s_r.field + STEP_ANGLE;
          s_nxt.tmr = 24'(SETTLE_CYC);
        end
      end
      TS_DIR: begin
        if (s_r.tmr != 24'h000000) begin
          s_nxt.tmr = s_r.tmr - 24'h000001;
        end else if (dir_delta <= 0) begin
          s_nxt.st = TS_ALARM;
          s_nxt.order_al = 1'b1;
        end else begin
          s_nxt.st = TS_STEP;
          s_nxt.steps = 2'h1;
          s_nxt.field = s_r.field + STEP_ANGLE;
          s_nxt.tmr = 24'(SETTLE_CYC);
        end
      end
      TS_STEP: begin
        if (s_r.tmr != 24'h000000) begin
          s_nxt.tmr = s_r.tmr - 24'h000001;
        end else if (s_r.steps == TUNE_STEPS) begin
          s_nxt.st = TS_CALC;
        end else begin
          s_nxt.steps = s_r.steps + 2'h1;
          s_nxt.field = s_r.field + STEP_ANGLE;
          s_nxt.tmr = 24'(SETTLE_CYC);
        end
      end
      TS_CALC: begin
        // Field angle less resolver angle scaled to motor electrical degrees
        s_nxt.phase = s_r.field - 16'(resolver_angle * (s_r.prm[P_MOT_POLES] / s_r.prm[P_RES_POLES]));
        s_nxt.st = TS_IDLE;
      end
      TS_ALARM: begin
        if (clr_wr) begin
          s_nxt.st = TS_IDLE;
          s_nxt.pole_al = 1'b0;
          s_nxt.order_al = 1'b0;
        end
      end
      default: s_nxt.st = TS_IDLE;
    endcase

    // Read data captured in the setup phase
    if (rd_setup) begin
      s_nxt.rdata = 32'h00000000;
      if (paddr == A_CTRL) begin
        s_nxt.rdata = {24'h000000, s_r.ctrl};
      end else if (idx >= 0) begin
        s_nxt.rdata = {16'h0000, s_r.prm[idx]};
      end else if (paddr == A_STATUS) begin
        s_nxt.rdata = {24'h000000, s_r.st, 2'h0, (s_r.st != TS_IDLE), s_r.order_al, s_r.pole_al};
      end else if (paddr == A_PHASE) begin
        s_nxt.rdata = {16'h0000, s_r.phase};
      end else if (paddr == A_SREF) begin
        s_nxt.rdata = {{16{s_r.sref[15]}}, s_r.sref};
      end else if (paddr == A_CUR) begin
        s_nxt.rdata = {{16{s_r.cur[15]}}, s_r.cur};
      end
    end
  end

  // Keeps the integrator inside the current command range
  function automatic longint clamp_l(input longint v);
    longint lim;
    lim = longint'(PCT_FULL) <<< FRAC_BITS;
    clamp_l = (v > lim) ? lim : ((v < -lim) ? -lim : v);
  endfunction : clamp_l

  // State register; reset gives defaults everywhere
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RESET;
      s_r.st <= TS_IDLE;
      for (int i = 0; i < NPRM; i++) s_r.prm[i] <= prm_reset(i);
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign speed_ref_out = s_r.sref;
  assign current_cmd = s_r.cur;
  assign tune_active = (s_r.st != TS_IDLE) && (s_r.st != TS_ALARM);
  assign tune_field_angle = s_r.field;
  assign pole_mismatch_alarm = s_r.pole_al;
  assign phase_order_alarm = s_r.order_al;
  assign resolver_phase_offset = s_r.phase;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence pole_pass_s;
    s_r.st == TS_POLE && ratio_ok;
  endsequence
  sequence dir_entered_s;
    s_r.st == TS_DIR && s_r.tmr == 24'(SETTLE_CYC);
  endsequence

  a_tune_start_gate: assert property (s_r.st == TS_IDLE && !start_ok |=> s_r.st != TS_POLE)
    else $error("tune left idle without a valid start");
  a_tune_seq_order: assert property (pole_pass_s |=> dir_entered_s ##1 s_r.st == TS_DIR)
    else $error("tune did not move from pole check to direction check");
  a_pole_alarm_raise: assert property (s_r.st == TS_POLE && !ratio_ok
    |=> s_r.st == TS_ALARM && pole_mismatch_alarm && !tune_active)
    else $error("pole mismatch did not raise its alarm");
  a_order_alarm_raise: assert property (s_r.st == TS_DIR && s_r.tmr == 24'h000000 && dir_delta <= 0
    |=> phase_order_alarm && s_r.st == TS_ALARM)
    else $error("direction fault did not raise its alarm");
  a_alarm_hold_state: assert property (s_r.st == TS_ALARM && !clr_wr
    |=> s_r.st == TS_ALARM && $stable(pole_mismatch_alarm) && $stable(phase_order_alarm))
    else $error("alarm state left without a clear");
  a_ref_dir_clamp: assert property (##1 speed_ref_out <= $signed({1'b0, $past(s_r.prm[P_CW_LIM])})
    && speed_ref_out >= -$signed({1'b0, $past(s_r.prm[P_CCW_LIM])}))
    else $error("speed reference outside direction limits");
  a_cw_switch_stop: assert property (s_nxt.cw_lock && tgt >= 0 |=> speed_ref_out <= 0)
    else $error("clockwise reference not zeroed at limit");
  a_integ_removed: assert property (s_r.ctrl[CB_INT_DIS] && drive_running |=> s_r.integ == 0)
    else $error("integral action present while disabled");
  a_cmd_saturate: assert property (current_cmd <= 16'sd1000 && current_cmd >= -16'sd1000)
    else $error("current command outside saturation range");
endmodule : srr_speed_regulator

// file: tb/srr_motor_model.sv
// Purpose: Behavioural motor with resolver at the far side of the regulator.
// Assumes: Resolver follows the commanded field; feedback follows the reference.
// Notes: Wiring can be reversed and motion slowed on command of the bench.
`timescale 1ns/1ps
module srr_motor_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] tune_field_angle,
  input wire logic signed [15:0] speed_ref_out,
  input wire logic reverse_wiring,
  input wire logic slow_motion,
  output logic [15:0] resolver_angle,
  output logic signed [15:0] speed_fb
);
  logic half_r; // Slow motor moves only every other cycle
  // Rotor tracks field; swapped phases turn it backwards
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resolver_angle <= 16'h0000;
      speed_fb <= 16'sh0000;
      half_r <= 1'b0;
    end else begin
      half_r <= ~half_r;
      if (!slow_motion || half_r) begin
        resolver_angle <= reverse_wiring ? -tune_field_angle : tune_field_angle;
        speed_fb <= speed_ref_out;
      end
    end
  end
endmodule : srr_motor_model

// file: tb/tb.sv
// Purpose: Self-checking bench of the speed reference regulator.
// Assumes: APB slave answers within a bounded wait; settle count shortened to 20.
// Notes: Reference rows in a table, tune and limits as hand tests.
`timescale 1ns/1ps
module tb import srr_pkg::*;;
  typedef struct {logic [1:0] pins; logic [7:0] ctrl; logic signed [15:0] exp;} srr_row_t;
  logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, sel_a = 1'b0, sel_b = 1'b0, cw_sw = 1'b1, ccw_sw = 1'b1;
  logic tq_mode = 1'b0, drive_running = 1'b0, reverse_wiring = 1'b0, slow_motion = 1'b1;
  logic signed [17:0] analog_ref_in = 18'sd50000; // Five volts
  logic signed [15:0] torque_ref_input = 16'sh0000, speed_fb, speed_ref_out, current_cmd;
  logic [15:0] resolver_angle, tune_field_angle, resolver_phase_offset;
  logic tune_active, pole_mismatch_alarm, phase_order_alarm;
  int n_errors = 0, num_checks = 0;
  srr_row_t rows [8];
  always #25 clk = ~clk; // 20 MHz
  srr_speed_regulator #(.SETTLE_CYC(20)) u_srr_speed_regulator (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_select_a_input(sel_a),
    .ref_select_b_input(sel_b), .cw_limit_switch(cw_sw), .ccw_limit_switch(ccw_sw),
    .torque_mode_select(tq_mode), .drive_running(drive_running),
    .analog_ref_in(analog_ref_in), .torque_ref_input(torque_ref_input), .speed_fb(speed_fb),
    .resolver_angle(resolver_angle), .speed_ref_out(speed_ref_out),
    .current_cmd(current_cmd), .tune_active(tune_active),
    .tune_field_angle(tune_field_angle), .pole_mismatch_alarm(pole_mismatch_alarm),
    .phase_order_alarm(phase_order_alarm), .resolver_phase_offset(resolver_phase_offset));
  srr_motor_model u_srr_motor_model (.clk(clk), .sys_rst(sys_rst),
    .tune_field_angle(tune_field_angle), .speed_ref_out(speed_ref_out),
    .reverse_wiring(reverse_wiring), .slow_motion(slow_motion),
    .resolver_angle(resolver_angle), .speed_fb(speed_fb));
  // Setup cycle, then access held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1); // Only the watchdog ends a wait if pready never rises
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  function automatic logic [7:0] pa(input int i);
    pa = PRM_BASE + 8'(4 * i); // Parameter word address
  endfunction : pa
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Start, wait out the sequence, check alarms, then clear them
  task automatic tune(input logic run, input logic [15:0] poles, input logic rev,
                      input logic [1:0] exp_al, input logic exp_act);
    drive_running <= run; reverse_wiring <= rev;
    apb(1'b1, pa(P_MOT_POLES), 32'(poles));
    apb(1'b1, A_TUNE, 32'(CMD_START));
    repeat (3) @(posedge clk);
    chk(32'(tune_active), 32'(exp_act));
    repeat (200) @(posedge clk);
    chk(32'(tune_active), 32'h0);
    chk(32'({phase_order_alarm, pole_mismatch_alarm}), 32'(exp_al));
    apb(1'b1, A_TUNE, 32'(CMD_CLEAR));
    repeat (3) @(posedge clk);
    chk(32'({phase_order_alarm, pole_mismatch_alarm, tune_active}), 32'h0);
  endtask : tune
  // Watchdog far beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    rows[0] = '{2'b10, 8'h30, 16'sd500};
    rows[1] = '{2'b01, 8'h30, 16'sd100};
    rows[2] = '{2'b11, 8'h30, 16'sd200};
    rows[3] = '{2'b00, 8'h30, -16'sd300};
    rows[4] = '{2'b00, 8'h31, 16'sd500};
    rows[5] = '{2'b00, 8'h32, 16'sd100};
    rows[6] = '{2'b00, 8'h33, 16'sd200};
    rows[7] = '{2'b10, 8'h34, -16'sd500};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    chk(32'(current_cmd), 32'h0);
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'(CTRL_RESET));
    apb(1'b0, pa(P_FS_MV), 32'h0);
    chk(rd, 32'h2710);
    apb(1'b0, pa(P_BREAK), 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk(32'(er), 32'h1);
    // Integrator preload seen as first current command, zero speed error
    apb(1'b1, pa(P_PRELOAD), 32'd100);
    @(posedge clk); // New preload must reach the integrator while stopped
    drive_running <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(current_cmd), 32'd100);
    apb(1'b1, A_CTRL, 32'hb0);
    repeat (3) @(posedge clk);
    chk(32'(current_cmd), 32'h0);
    drive_running <= 1'b0;
    apb(1'b1, pa(P_PRESET1), 32'd100);
    apb(1'b1, pa(P_PRESET2), 32'd200);
    apb(1'b1, pa(P_PRESET3), 32'hfffffed4);
    foreach (rows[i]) begin
      {sel_a, sel_b} <= rows[i].pins;
      apb(1'b1, A_CTRL, 32'(rows[i].ctrl));
      repeat (6) @(posedge clk);
      chk(32'(speed_ref_out), 32'(rows[i].exp));
    end
    // Offset, half full scale, per-direction clamps
    apb(1'b1, A_CTRL, 32'h30);
    apb(1'b1, pa(P_REF_OFS), 32'd10000);
    apb(1'b1, pa(P_FS_MV), 32'd5000);
    apb(1'b1, pa(P_CW_LIM), 32'd700);
    apb(1'b1, pa(P_CCW_LIM), 32'd150);
    {sel_a, sel_b} <= 2'b10;
    repeat (6) @(posedge clk);
    chk(32'(speed_ref_out), 32'd700);
    {sel_a, sel_b} <= 2'b00;
    repeat (6) @(posedge clk);
    chk(32'(speed_ref_out), -32'sd150);
    // Switch open stops and locks; reversal frees the other way
    {sel_a, sel_b} <= 2'b01;
    cw_sw <= 1'b0;
    repeat (6) @(posedge clk);
    chk(32'(speed_ref_out), 32'h0);
    cw_sw <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(speed_ref_out), 32'h0);
    {sel_a, sel_b} <= 2'b00;
    repeat (6) @(posedge clk);
    chk(32'(speed_ref_out), -32'sd150);
    // Ramp of 1 ms to full scale: 200 cycles give about 10
    apb(1'b1, pa(P_CCW_DEC), 32'd1);
    apb(1'b1, pa(P_CW_ACC), 32'd1);
    apb(1'b1, A_CTRL, 32'h38);
    {sel_a, sel_b} <= 2'b01;
    repeat (1000) @(posedge clk);
    {sel_a, sel_b} <= 2'b00;
    apb(1'b1, pa(P_PRESET3), 32'd0);
    repeat (4000) @(posedge clk);
    {sel_a, sel_b} <= 2'b01;
    repeat (200) @(posedge clk);
    chk(32'(speed_ref_out > 16'sd3 && speed_ref_out < 16'sd20), 32'h1);
    // Torque mode with offset and gain, then saturation
    apb(1'b1, pa(P_TQ_OFS), 32'd50);
    apb(1'b1, pa(P_TQ_GAIN), 32'd2000);
    tq_mode <= 1'b1; torque_ref_input <= 16'sd200; drive_running <= 1'b1;
    repeat (6) @(posedge clk);
    chk(32'(current_cmd), 32'd300);
    torque_ref_input <= 16'sd900;
    repeat (6) @(posedge clk);
    chk(32'(current_cmd), 32'd1000);
    // Speed plus torque: settled speed loop, integral off, torque added on top
    tq_mode <= 1'b0;
    torque_ref_input <= 16'sd200;
    apb(1'b1, A_CTRL, 32'hf0);
    repeat (6) @(posedge clk);
    chk(32'(current_cmd), 32'd300);
    apb(1'b1, pa(P_KEY), 32'(ACCESS_KEY_CODE));
    tune(1'b1, 16'd6, 1'b0, 2'b00, 1'b0);
    tune(1'b0, 16'd5, 1'b0, 2'b01, 1'b0);
    // Clean run first, from a rotor resting at field zero
    tune(1'b0, 16'd6, 1'b0, 2'b00, 1'b1);
    // Four 120 degree steps wrap to 0x5554; aligned rotor gives field less 3x angle
    chk(32'(tune_field_angle), 32'h5554);
    chk(32'(resolver_phase_offset), 32'h5558);
    tune(1'b0, 16'd6, 1'b1, 2'b10, 1'b1);
    print_verdict();
  end
endmodule : tb
